// file: pkg/ssq_params.svh
// constants of the stage speed sequencer: map, field positions, resets
// assumes inclusion by bare name from the package, the checker and the bench
`ifndef SSQ_PARAMS_SVH
`define SSQ_PARAMS_SVH

`define SSQ_NUM_STAGES      7
`define SSQ_CLK_MHZ         200
`define SSQ_TIME_UNIT_MS    100
`define SSQ_TICK_CYCLES     (`SSQ_TIME_UNIT_MS * 1000 * `SSQ_CLK_MHZ)

`define SSQ_ADDR_CTRL       12'h000
`define SSQ_ADDR_OFFSET     12'h004
`define SSQ_ADDR_UPPER      12'h008
`define SSQ_ADDR_LOWER      12'h00C
`define SSQ_ADDR_TRIM_STEP  12'h010
`define SSQ_ADDR_STATUS     12'h014
`define SSQ_ADDR_TRIM       12'h018
`define SSQ_STAGE_REGION    4'h1

`define SSQ_FLD_DIR         3'h0
`define SSQ_FLD_ACCEL       3'h1
`define SSQ_FLD_DECEL       3'h2
`define SSQ_FLD_FREQ        3'h3
`define SSQ_FLD_RUN_TIME    3'h4
`define SSQ_FLD_WAIT_TIME   3'h5

`define SSQ_CTRL_SRC_LSB    0
`define SSQ_CTRL_MODE_LSB   2
`define SSQ_CTRL_CMP_EN_BIT 4
`define SSQ_CTRL_CMP_MD_BIT 5
`define SSQ_ST_DIR_BIT      16
`define SSQ_ST_RUN_BIT      17
`define SSQ_ST_STAGE_LSB    18
`define SSQ_ST_PHASE_LSB    21

`define SSQ_TIME_MIN        15'h0001
`define SSQ_TIME_MAX        15'h7530
`define SSQ_TIME_DEF        15'h00C8
`define SSQ_WAIT_DEF        15'h0000
`define SSQ_FREQ_STEP_DEF   16'h01F4
`define SSQ_OFFSET_MAX      16'h07D0
`define SSQ_OFFSET_DEF      16'h0000
`define SSQ_ANALOG_MAX      10'h3E8
`define SSQ_UPPER_DEF       16'h1388
`define SSQ_LOWER_DEF       16'h0000
`define SSQ_TRIM_STEP_DEF   16'h0001
`define SSQ_REV_DEF_MASK    7'h0A

`endif

// file: pkg/ssq_pkg.sv
// types of the stage speed sequencer
// assumes ssq_params.svh on the include path
`include "ssq_params.svh"
package ssq_pkg;
  typedef enum logic [1:0] {
    SSQ_SRC_KEYPAD = 2'h0,
    SSQ_SRC_TERM   = 2'h1,
    SSQ_SRC_REMOTE = 2'h2
  } ssq_src_type;

  typedef enum logic [1:0] {
    SSQ_MODE_MULTI = 2'h0,
    SSQ_MODE_AUTO  = 2'h1,
    SSQ_MODE_EIGHT = 2'h2
  } ssq_mode_type;

  typedef enum logic [1:0] {
    SSQ_PH_IDLE,
    SSQ_PH_RUN,
    SSQ_PH_WAIT
  } ssq_phase_type;

  typedef struct packed {
    logic       run;
    logic       forward_run_terminal;
    logic       backward_run_terminal;
    logic       hold;
    logic       up;
    logic       down;
    logic [2:0] stage_sel;
  } ssq_term_type;

  typedef struct packed {
    logic        run;
    logic        dir;
    logic [15:0] freq;
    logic [14:0] accel;
    logic [14:0] decel;
    logic [2:0]  stage;
  } ssq_drive_cmd_type;
endpackage : ssq_pkg

// file: src/ssq_stage_timer.sv
// stage duration timer counting in 0.1 s units
// assumes a load pulse with a nonzero count; done is a one-cycle pulse
`timescale 1ns/10ps
module ssq_stage_timer #(
  parameter int TICK_CYCLES = `SSQ_TICK_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_clk_en,
  input  wire logic        i_load,
  input  wire logic [14:0] i_count,
  output logic             o_done
);
  localparam int PW = $clog2(TICK_CYCLES + 1);

  initial begin
    if (TICK_CYCLES < 1) $error("ssq_stage_timer: TICK_CYCLES below 1");
  end

  typedef struct packed {
    logic [PW-1:0] presc;
    logic [14:0]   remain;
    logic          done;
  } ssq_tmr_state_type;

  ssq_tmr_state_type r_ff, nxt_r;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.done = 1'b0;
    if (i_load) begin
      nxt_r.remain = i_count;
      nxt_r.presc  = '0;
    end else if (r_ff.remain != 15'h0000) begin
      if (r_ff.presc == PW'(TICK_CYCLES - 1)) begin
        nxt_r.presc  = '0;
        nxt_r.remain = r_ff.remain - 15'h0001;
        nxt_r.done   = (r_ff.remain == 15'h0001);
      end else begin
        nxt_r.presc = r_ff.presc + PW'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r_ff <= '0;
    end else if (i_clk_en) begin
      r_ff <= nxt_r;
    end
  end

  assign o_done = r_ff.done;
endmodule : ssq_stage_timer

// file: src/ssq_sequencer.sv
// stage speed sequencer: seven stage profiles, direction source,
// auto-circulating timing, compound frequency and live trimming
// assumes an AXI4-Lite master and terminal inputs synchronous to i_clk
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module ssq_sequencer import ssq_pkg::*; #(
  parameter int NUM_STAGES  = `SSQ_NUM_STAGES,
  parameter int TICK_CYCLES = `SSQ_TICK_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_clk_en,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [11:0] i_s_axi_awaddr,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  output logic [1:0]       o_s_axi_bresp,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  input  wire logic [11:0] i_s_axi_araddr,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  input  wire ssq_term_type i_term,
  input  wire logic [9:0]  i_second_analog_input,
  output ssq_drive_cmd_type o_cmd
);
  localparam int NS = NUM_STAGES;
  localparam logic [6:0] REV_MASK = `SSQ_REV_DEF_MASK;

  initial begin
    if (NS < 1 || NS > 7) $error("ssq_sequencer: NUM_STAGES must be 1..7");
    if (TICK_CYCLES < 1) $error("ssq_sequencer: TICK_CYCLES below 1");
  end

  typedef struct packed {
    logic                  aw_got;
    logic                  w_got;
    logic [11:0]           awaddr;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
    ssq_src_type           cmd_src;
    ssq_mode_type          stage_mode;
    logic                  cmp_en;
    logic                  cmp_mode;
    logic [15:0]           cmp_offset;
    logic [15:0]           upper;
    logic [15:0]           lower;
    logic [15:0]           trim_step;
    logic [NS-1:0]         dir;
    logic [NS-1:0][14:0]   accel;
    logic [NS-1:0][14:0]   decel;
    logic [NS-1:0][14:0]   run_t;
    logic [NS-1:0][14:0]   wait_t;
    logic [NS-1:0][15:0]   freq;
    logic [17:0]           trim;
    logic [2:0]            last_sel;
    ssq_phase_type         phase;
    logic [2:0]            auto_idx;
    ssq_drive_cmd_type     cmd;
  } ssq_state_type;

  function automatic ssq_state_type init_state();
    ssq_state_type s;
    s = '0;
    s.cmd_src    = SSQ_SRC_KEYPAD;
    s.stage_mode = SSQ_MODE_MULTI;
    s.cmp_offset = `SSQ_OFFSET_DEF;
    s.upper      = `SSQ_UPPER_DEF;
    s.lower      = `SSQ_LOWER_DEF;
    s.trim_step  = `SSQ_TRIM_STEP_DEF;
    s.phase      = SSQ_PH_IDLE;
    for (int i = 0; i < NS; i++) begin
      s.dir[i]    = REV_MASK[i];
      s.accel[i]  = `SSQ_TIME_DEF;
      s.decel[i]  = `SSQ_TIME_DEF;
      s.run_t[i]  = `SSQ_TIME_DEF;
      s.wait_t[i] = `SSQ_WAIT_DEF;
      s.freq[i]   = 16'(`SSQ_FREQ_STEP_DEF * (i + 1));
    end
    return s;
  endfunction : init_state

  localparam ssq_state_type RESET_STATE = init_state();

  function automatic logic [14:0] clamp_time(input logic [31:0] v,
                                             input logic [14:0] lo);
    if (v[14:0] < lo || v[31:15] != '0) begin
      return (v[31:15] != '0) ? `SSQ_TIME_MAX : lo;
    end
    return (v[14:0] > `SSQ_TIME_MAX) ? `SSQ_TIME_MAX : v[14:0];
  endfunction : clamp_time

  function automatic logic [32:0] read_word(input ssq_state_type s,
                                            input logic [11:0] a);
    logic [2:0]  st;
    logic [31:0] d;
    logic        ok;
    st = a[7:5];
    d  = '0;
    ok = 1'b1;
    if (a[11:8] == `SSQ_STAGE_REGION && a[1:0] == 2'h0 && st < NS) begin
      case (a[4:2])
        `SSQ_FLD_DIR:       d[0]    = s.dir[st];
        `SSQ_FLD_ACCEL:     d[14:0] = s.accel[st];
        `SSQ_FLD_DECEL:     d[14:0] = s.decel[st];
        `SSQ_FLD_FREQ:      d[15:0] = s.freq[st];
        `SSQ_FLD_RUN_TIME:  d[14:0] = s.run_t[st];
        `SSQ_FLD_WAIT_TIME: d[14:0] = s.wait_t[st];
        default:            ok = 1'b0;
      endcase
    end else begin
      case (a)
        `SSQ_ADDR_CTRL: begin
          d[`SSQ_CTRL_SRC_LSB +: 2]  = s.cmd_src;
          d[`SSQ_CTRL_MODE_LSB +: 2] = s.stage_mode;
          d[`SSQ_CTRL_CMP_EN_BIT]    = s.cmp_en;
          d[`SSQ_CTRL_CMP_MD_BIT]    = s.cmp_mode;
        end
        `SSQ_ADDR_OFFSET:    d[15:0] = s.cmp_offset;
        `SSQ_ADDR_UPPER:     d[15:0] = s.upper;
        `SSQ_ADDR_LOWER:     d[15:0] = s.lower;
        `SSQ_ADDR_TRIM_STEP: d[15:0] = s.trim_step;
        `SSQ_ADDR_STATUS: begin
          d[15:0]                     = s.cmd.freq;
          d[`SSQ_ST_DIR_BIT]          = s.cmd.dir;
          d[`SSQ_ST_RUN_BIT]          = s.cmd.run;
          d[`SSQ_ST_STAGE_LSB +: 3]   = s.cmd.stage;
          d[`SSQ_ST_PHASE_LSB +: 2]   = s.phase;
        end
        `SSQ_ADDR_TRIM:      d = {{14{s.trim[17]}}, s.trim};
        default:             ok = 1'b0;
      endcase
    end
    return {ok, d};
  endfunction : read_word

  ssq_state_type r_ff, nxt_r;
  logic          tmr_load;
  logic [14:0]   tmr_count;
  logic          tmr_done;

  logic [32:0]   wr_old;
  logic [31:0]   wv;
  logic [2:0]    ws;
  logic          run_req;
  logic          term_dir;
  logic          valid;
  logic [2:0]    idx;
  logic [2:0]    nxt_idx;
  logic [17:0]   comp;
  logic [17:0]   sum;

  assign o_s_axi_awready = !r_ff.aw_got && !r_ff.bvalid;
  assign o_s_axi_wready  = !r_ff.w_got && !r_ff.bvalid;
  assign o_s_axi_arready = !r_ff.rvalid;

  always_comb begin
    nxt_r     = r_ff;
    tmr_load  = 1'b0;
    tmr_count = '0;
    wr_old    = read_word(r_ff, r_ff.awaddr);
    ws        = r_ff.awaddr[7:5];
    for (int b = 0; b < 4; b++) begin
      wv[8*b +: 8] = r_ff.wstrb[b] ? r_ff.wdata[8*b +: 8]
                                   : wr_old[8*b +: 8];
    end
    // bus slave: address and data in either order
    if (i_s_axi_awvalid && o_s_axi_awready) begin
      nxt_r.aw_got = 1'b1;
      nxt_r.awaddr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      nxt_r.w_got = 1'b1;
      nxt_r.wdata = i_s_axi_wdata;
      nxt_r.wstrb = i_s_axi_wstrb;
    end
    if (r_ff.bvalid && i_s_axi_bready) nxt_r.bvalid = 1'b0;
    if (r_ff.aw_got && r_ff.w_got) begin
      nxt_r.aw_got = 1'b0;
      nxt_r.w_got  = 1'b0;
      nxt_r.bvalid = 1'b1;
      nxt_r.bresp  = wr_old[32] ? 2'h0 : 2'h2;
      if (r_ff.awaddr[11:8] == `SSQ_STAGE_REGION && wr_old[32]) begin
        case (r_ff.awaddr[4:2])
          `SSQ_FLD_DIR:       nxt_r.dir[ws] = wv[0];
          `SSQ_FLD_ACCEL:     nxt_r.accel[ws] =
                                clamp_time(wv, `SSQ_TIME_MIN);
          `SSQ_FLD_DECEL:     nxt_r.decel[ws] =
                                clamp_time(wv, `SSQ_TIME_MIN);
          `SSQ_FLD_FREQ:      nxt_r.freq[ws] = wv[15:0];
          `SSQ_FLD_RUN_TIME:  nxt_r.run_t[ws] =
                                clamp_time(wv, `SSQ_TIME_MIN);
          `SSQ_FLD_WAIT_TIME: nxt_r.wait_t[ws] =
                                clamp_time(wv, 15'h0000);
          default:            nxt_r.bresp = 2'h2;
        endcase
      end else if (wr_old[32]) begin
        case (r_ff.awaddr)
          `SSQ_ADDR_CTRL: begin
            nxt_r.cmd_src    = ssq_src_type'(wv[`SSQ_CTRL_SRC_LSB +: 2]);
            nxt_r.stage_mode =
              ssq_mode_type'(wv[`SSQ_CTRL_MODE_LSB +: 2]);
            nxt_r.cmp_en     = wv[`SSQ_CTRL_CMP_EN_BIT];
            nxt_r.cmp_mode   = wv[`SSQ_CTRL_CMP_MD_BIT];
          end
          `SSQ_ADDR_OFFSET: nxt_r.cmp_offset =
            (wv[15:0] > `SSQ_OFFSET_MAX) ? `SSQ_OFFSET_MAX
                                         : wv[15:0];
          `SSQ_ADDR_UPPER:     nxt_r.upper = wv[15:0];
          `SSQ_ADDR_LOWER:     nxt_r.lower = wv[15:0];
          `SSQ_ADDR_TRIM_STEP: nxt_r.trim_step = wv[15:0];
          default:             nxt_r.bresp = 2'h2;
        endcase
      end
    end
    if (r_ff.rvalid && i_s_axi_rready) nxt_r.rvalid = 1'b0;
    if (i_s_axi_arvalid && o_s_axi_arready) begin
      nxt_r.rvalid = 1'b1;
      {nxt_r.rresp[1], nxt_r.rdata} = read_word(r_ff, i_s_axi_araddr);
      nxt_r.rresp[1] = !nxt_r.rresp[1];
      nxt_r.rresp[0] = 1'b0;
    end

    // run and direction source
    term_dir = i_term.backward_run_terminal && !i_term.forward_run_terminal;
    run_req  = (r_ff.cmd_src == SSQ_SRC_TERM)
             ? (i_term.hold && (i_term.forward_run_terminal || i_term.backward_run_terminal))
             : i_term.run;

    // auto-circulating sequence
    nxt_idx = (r_ff.auto_idx == 3'(NS - 1)) ? 3'h0
                                            : r_ff.auto_idx + 3'h1;
    case (r_ff.phase)
      SSQ_PH_IDLE: begin
        if (r_ff.stage_mode == SSQ_MODE_AUTO && run_req) begin
          nxt_r.phase    = SSQ_PH_RUN;
          nxt_r.auto_idx = 3'h0;
          tmr_load       = 1'b1;
          tmr_count      = r_ff.run_t[0];
        end
      end
      SSQ_PH_RUN: begin
        if (r_ff.stage_mode != SSQ_MODE_AUTO || !run_req) begin
          nxt_r.phase = SSQ_PH_IDLE;
        end else if (tmr_done) begin
          tmr_load = 1'b1;
          if (r_ff.wait_t[r_ff.auto_idx] != 15'h0000) begin
            nxt_r.phase = SSQ_PH_WAIT;
            tmr_count   = r_ff.wait_t[r_ff.auto_idx];
          end else begin
            nxt_r.auto_idx = nxt_idx;
            tmr_count      = r_ff.run_t[nxt_idx];
          end
        end
      end
      SSQ_PH_WAIT: begin
        if (r_ff.stage_mode != SSQ_MODE_AUTO || !run_req) begin
          nxt_r.phase = SSQ_PH_IDLE;
        end else if (tmr_done) begin
          nxt_r.phase    = SSQ_PH_RUN;
          nxt_r.auto_idx = nxt_idx;
          tmr_load       = 1'b1;
          tmr_count      = r_ff.run_t[nxt_idx];
        end
      end
      default: nxt_r.phase = SSQ_PH_IDLE;
    endcase

    // active stage: selected by inputs outside auto mode
    if (r_ff.stage_mode == SSQ_MODE_AUTO) begin
      valid = (r_ff.phase == SSQ_PH_RUN);
      idx   = r_ff.auto_idx;
    end else begin
      valid = run_req && i_term.stage_sel != 3'h0
           && i_term.stage_sel <= 3'(NS);
      idx   = valid ? i_term.stage_sel - 3'h1 : 3'h0;
    end

    // live trim, never written back to stage settings
    nxt_r.last_sel = i_term.stage_sel;
    if (!valid || r_ff.stage_mode == SSQ_MODE_AUTO
        || i_term.stage_sel != r_ff.last_sel) begin
      nxt_r.trim = '0;
    end else if (i_term.up && !i_term.down) begin
      nxt_r.trim = r_ff.trim + {2'h0, r_ff.trim_step};
      if ($signed(nxt_r.trim) > $signed({2'h0, r_ff.upper}))
        nxt_r.trim = {2'h0, r_ff.upper};
    end else if (i_term.down && !i_term.up) begin
      nxt_r.trim = r_ff.trim - {2'h0, r_ff.trim_step};
      if ($signed(nxt_r.trim) < -$signed({2'h0, r_ff.upper}))
        nxt_r.trim = -{2'h0, r_ff.upper};
    end

    // compound frequency, not in auto mode
    comp = '0;
    if (r_ff.cmp_en && r_ff.stage_mode != SSQ_MODE_AUTO) begin
      if (!r_ff.cmp_mode) begin
        comp = {2'h0, r_ff.cmp_offset};
      end else begin
        comp = (i_second_analog_input > `SSQ_ANALOG_MAX)
             ? {8'h00, `SSQ_ANALOG_MAX}
             : {8'h00, i_second_analog_input};
      end
    end
    sum = {2'h0, r_ff.freq[idx]} + comp + r_ff.trim;
    if ($signed(sum) < $signed({2'h0, r_ff.lower}))
      sum = {2'h0, r_ff.lower};
    if ($signed(sum) > $signed({2'h0, r_ff.upper}))
      sum = {2'h0, r_ff.upper};

    nxt_r.cmd.run   = valid;
    nxt_r.cmd.dir   = (r_ff.cmd_src == SSQ_SRC_TERM) ? term_dir
                    : r_ff.dir[idx];
    nxt_r.cmd.freq  = valid ? sum[15:0] : 16'h0000;
    nxt_r.cmd.accel = r_ff.accel[idx];
    nxt_r.cmd.decel = r_ff.decel[idx];
    nxt_r.cmd.stage = valid ? idx + 3'h1 : 3'h0;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r_ff <= RESET_STATE;
    end else if (i_clk_en) begin
      r_ff <= nxt_r;
    end
  end

  ssq_stage_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_clk_en  (i_clk_en),
    .i_load    (tmr_load),
    .i_count   (tmr_count),
    .o_done    (tmr_done)
  );

  assign o_s_axi_bvalid = r_ff.bvalid;
  assign o_s_axi_bresp  = r_ff.bresp;
  assign o_s_axi_rvalid = r_ff.rvalid;
  assign o_s_axi_rdata  = r_ff.rdata;
  assign o_s_axi_rresp  = r_ff.rresp;
  assign o_cmd          = r_ff.cmd;
endmodule : ssq_sequencer

// file: test/ssq_sequencer_props.sv
// checker of the stage speed sequencer ports
// assumes AW and W offered together and full-word strobes
`timescale 1ns/10ps
`include "ssq_params.svh"
module ssq_sequencer_props import ssq_pkg::*; #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic              i_clk,
  input wire logic              i_reset_n,
  input wire logic              i_s_axi_awvalid,
  input wire logic              o_s_axi_awready,
  input wire logic [11:0]       i_s_axi_awaddr,
  input wire logic              i_s_axi_wvalid,
  input wire logic              o_s_axi_wready,
  input wire logic [31:0]       i_s_axi_wdata,
  input wire ssq_term_type      i_term,
  input wire ssq_drive_cmd_type o_cmd
);
  localparam logic [6:0]  REV_M   = `SSQ_REV_DEF_MASK;
  localparam logic [15:0] RUN_CYC = 16'(200 * TICK_CYCLES + 1);
  logic        pv_ff;
  logic [11:0] pa_ff;
  logic [15:0] pd_ff;
  logic [3:0]  ctl_ff;
  logic [15:0] upp_ff;
  logic [15:0] cnt_ff;
  logic [2:0]  stg_ff;
  logic [1:0]  src;
  logic [1:0]  mode;
  assign src  = ctl_ff[1:0];
  assign mode = ctl_ff[3:2];
  // shadow of control and upper limit, committed with the register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pv_ff  <= 1'b0;
      pa_ff  <= 12'h000;
      pd_ff  <= 16'h0000;
      ctl_ff <= 4'h0;
      upp_ff <= `SSQ_UPPER_DEF;
      cnt_ff <= 16'h0000;
      stg_ff <= 3'h0;
    end else begin
      pv_ff  <= i_s_axi_awvalid && o_s_axi_awready &&
                i_s_axi_wvalid && o_s_axi_wready;
      pa_ff  <= i_s_axi_awaddr;
      pd_ff  <= i_s_axi_wdata[15:0];
      if (pv_ff && pa_ff == `SSQ_ADDR_CTRL) ctl_ff <= pd_ff[3:0];
      if (pv_ff && pa_ff == `SSQ_ADDR_UPPER) upp_ff <= pd_ff;
      stg_ff <= o_cmd.stage;
      cnt_ff <= (o_cmd.stage != stg_ff) ? 16'h0001 : cnt_ff + 16'h0001;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence step_s;
    stg_ff != 3'h0 && o_cmd.stage != 3'h0 && o_cmd.stage != stg_ff;
  endsequence
  idle_zero_a: assert property (!o_cmd.run |-> o_cmd.freq == 16'h0000 && o_cmd.stage == 3'h0)
    else $error("idle command not zero");
  stored_dir_a: assert property (o_cmd.run && $past(src) != 2'h1 |-> o_cmd.dir == REV_M[o_cmd.stage - 3'h1])
    else $error("stored direction not used");
  term_dir_a: assert property ($past(src == 2'h1 && mode != 2'h1 && i_term.stage_sel != 3'h0) |-> o_cmd.run == $past(i_term.hold && (i_term.forward_run_terminal || i_term.backward_run_terminal)) && (!o_cmd.run || o_cmd.dir == $past(i_term.backward_run_terminal && !i_term.forward_run_terminal)))
    else $error("terminal direction wrong");
  stage_sel_a: assert property ($past(i_term.run && src != 2'h1 && mode != 2'h1 && i_term.stage_sel != 3'h0) |-> o_cmd.run && o_cmd.stage == $past(i_term.stage_sel))
    else $error("selected stage not run");
  sel_none_a: assert property ($past(mode != 2'h1 && i_term.stage_sel == 3'h0) |-> !o_cmd.run)
    else $error("running with no stage");
  time_range_a: assert property (o_cmd.run |-> o_cmd.accel inside {[1:30000]} && o_cmd.decel inside {[1:30000]})
    else $error("ramp time out of range");
  auto_freq_a: assert property (o_cmd.run && $past(mode) == 2'h1 && $past(mode, 2) == 2'h1 && $past(upp_ff) >= 16'h0DAC |-> o_cmd.freq == 16'(500 * o_cmd.stage))
    else $error("auto stage frequency wrong");
  auto_len_a: assert property (step_s and $past(mode) == 2'h1 |-> cnt_ff == RUN_CYC)
    else $error("auto stage length wrong");
  clamp_hi_a: assert property (o_cmd.run |-> o_cmd.freq <= $past(upp_ff))
    else $error("frequency above upper limit");
endmodule : ssq_sequencer_props
bind ssq_sequencer ssq_sequencer_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (
  .i_clk, .i_reset_n, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_awaddr,
  .i_s_axi_wvalid, .o_s_axi_wready, .i_s_axi_wdata, .i_term, .o_cmd);

// file: test/ssq_drive_model.sv
// far side: control terminals and a slow drive ramp
// assumes bench requests, registered like real terminal inputs
`timescale 1ns/10ps
module ssq_drive_model import ssq_pkg::*; (
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  input  wire ssq_term_type      i_term_req,
  input  wire logic [9:0]        i_analog_req,
  input  wire ssq_drive_cmd_type i_cmd,
  output ssq_term_type           o_term,
  output logic [9:0]             o_analog,
  output logic [15:0]            o_ramp_freq
);
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_term      <= '0;
      o_analog    <= 10'h000;
      o_ramp_freq <= 16'h0000;
    end else begin
      o_term   <= i_term_req;
      o_analog <= i_analog_req;
      if (o_ramp_freq < i_cmd.freq) o_ramp_freq <= o_ramp_freq + 16'h0001;
      else if (o_ramp_freq > i_cmd.freq) o_ramp_freq <= o_ramp_freq - 16'h0001;
    end
  end
endmodule : ssq_drive_model

// file: test/ssq_sequencer_tb.sv
// self-checking bench of the stage speed sequencer
// assumes the drive model on the terminal side and the bound checker
`timescale 1ns/10ps
`include "ssq_params.svh"
module ssq_sequencer_tb import ssq_pkg::*; ;
  localparam int TK = 4;
  logic clk, rst_n, awv, awr, wv, wrr, bv, bre, arv, arr, rv, rre;
  logic [11:0] awa, ara, ba;
  logic [31:0] wd, rdd;
  logic [1:0]  bresp, rresp;
  logic [9:0]  an;
  ssq_term_type tr, term;
  ssq_drive_cmd_type cmd;
  logic [9:0]  an_d;
  int n_fail, checks_done, s, off, av, up, n;
  logic ce, cm;
  logic [1:0] md;
  always #2.5 clk = ~clk;
  ssq_sequencer #(.TICK_CYCLES(TK)) i_ssq_sequencer (.i_clk(clk),
    .i_reset_n(rst_n), .i_clk_en(1'b1), .i_s_axi_awvalid(awv),
    .o_s_axi_awready(awr), .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wrr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF),
    .o_s_axi_bvalid(bv), .i_s_axi_bready(bre), .o_s_axi_bresp(bresp),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rre), .o_s_axi_rdata(rdd),
    .o_s_axi_rresp(rresp), .i_term(term), .i_second_analog_input(an_d),
    .o_cmd(cmd));
  ssq_drive_model i_ssq_drive_model (.i_clk(clk), .i_reset_n(rst_n),
    .i_term_req(tr), .i_analog_req(an), .i_cmd(cmd), .o_term(term),
    .o_analog(an_d), .o_ramp_freq());
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic tmo(input int k);
    if (k >= 900) begin
      n_fail++;
      end_sim();
    end
  endtask : tmo
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    int k;
    logic ta, tw;
    k = 0; ta = 0; tw = 0;
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
    while (!(ta && tw) && k < 900) begin
      @(posedge clk); k++;
      if (awr && awv) begin ta = 1; awv <= 1'b0; end
      if (wrr && wv) begin tw = 1; wv <= 1'b0; end
    end
    bre <= 1'b1;
    do begin @(posedge clk); k++; end while (!bv && k < 900);
    bre <= 1'b0;
    tmo(k);
    chk(bresp, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    int k;
    k = 0;
    ara <= a; arv <= 1'b1;
    do begin @(posedge clk); k++; end while (!arr && k < 900);
    arv <= 1'b0; rre <= 1'b1;
    do begin @(posedge clk); k++; end while (!rv && k < 900);
    rre <= 1'b0;
    tmo(k);
    chk(rdd, e);
    chk(rresp, er);
  endtask : rd
  function automatic logic [15:0] exp_f(input int st, input int o,
                                        input int a, input int u);
    int f;
    f = 500 * st;
    if (ce) f += cm ? ((a > 1000) ? 1000 : a) : o;
    if (f > u) f = u;
    return 16'(f);
  endfunction : exp_f
  task automatic upd(input int k);
    repeat (k) @(posedge clk);
  endtask : upd
  initial begin
    clk = 0; rst_n = 0; awv = 0; wv = 0; bre = 0; arv = 0; rre = 0;
    awa = 0; ara = 0; wd = 0; an = 0; tr = '0; n_fail = 0; checks_done = 0;
    ce = 0; cm = 0;
    void'($urandom(32'hBE9E));
    upd(3);
    rst_n <= 1'b1;
    for (s = 0; s < 7; s++) begin
      ba = 12'h100 + 12'(s * 32);
      rd(ba, {31'h0, s == 1 || s == 3}, 2'h0);
      rd(ba + 12'h004, 32'h000000C8, 2'h0);
      rd(ba + 12'h008, 32'h000000C8, 2'h0);
      rd(ba + 12'h00C, 32'(500 * (s + 1)), 2'h0);
      rd(ba + 12'h010, 32'h000000C8, 2'h0);
      rd(ba + 12'h014, 32'h00000000, 2'h0);
    end
    rd(`SSQ_ADDR_CTRL, 32'h00000000, 2'h0);
    rd(`SSQ_ADDR_OFFSET, 32'h00000000, 2'h0);
    rd(12'hFFC, 32'h00000000, 2'h2);
    wr(`SSQ_ADDR_STATUS, 32'h00000001, 2'h2);
    wr(`SSQ_ADDR_OFFSET, 32'h00000BB8, 2'h0);
    rd(`SSQ_ADDR_OFFSET, 32'h000007D0, 2'h0);
    wr(12'h124, 32'h00000000, 2'h0);
    rd(12'h124, 32'h00000001, 2'h0);
    wr(12'h124, 32'h000000C8, 2'h0);
    for (int i = 0; i < 24; i++) begin
      md = i[0] ? 2'h2 : 2'h0;
      ce = i[1];
      cm = i[2];
      off = (i == 3) ? 2000 : $urandom % 2001;
      av = (i == 6) ? 1023 : $urandom % 1024;
      up = (i % 5 == 4) ? 1200 : 5000;
      s = 1 + $urandom % 7;
      wr(`SSQ_ADDR_OFFSET, 32'(off), 2'h0);
      wr(`SSQ_ADDR_UPPER, 32'(up), 2'h0);
      wr(`SSQ_ADDR_CTRL, {26'h0, cm, ce, md, 2'h0}, 2'h0);
      tr.run <= 1'b1;
      tr.stage_sel <= 3'(s);
      an <= 10'(av);
      upd(4);
      chk(cmd.stage, 32'(s));
      chk(cmd.dir, s == 2 || s == 4);
      chk(cmd.accel, 32'h000000C8);
      chk(cmd.freq, exp_f(s, off, av, up));
    end
    ce = 0;
    upd(1000);
    chk(cmd.stage, 32'(s));
    tr.stage_sel <= 3'h0;
    upd(4);
    chk(cmd.run, 32'h0);
    wr(`SSQ_ADDR_UPPER, 32'h00001388, 2'h0);
    wr(`SSQ_ADDR_CTRL, 32'h00000001, 2'h0);
    tr.stage_sel <= 3'h2;
    for (int k = 0; k < 8; k++) begin
      tr.hold <= k[2];
      tr.forward_run_terminal <= k[1];
      tr.backward_run_terminal <= k[0];
      upd(4);
      chk(cmd.run, k[2] && (k[1] || k[0]));
      if (cmd.run === 1'b1) chk(cmd.dir, k[0] && !k[1]);
    end
    wr(`SSQ_ADDR_CTRL, 32'h00000000, 2'h0);
    wr(`SSQ_ADDR_TRIM_STEP, 32'h00000064, 2'h0);
    tr.stage_sel <= 3'h3;
    upd(4);
    repeat (3) begin
      tr.up <= 1'b1;
      upd(1);
      tr.up <= 1'b0;
      upd(1);
    end
    tr.down <= 1'b1;
    upd(1);
    tr.down <= 1'b0;
    upd(4);
    chk(cmd.freq, 32'h000006A4);
    rd(12'h14C, 32'h000005DC, 2'h0);
    tr.stage_sel <= 3'h4;
    upd(3);
    tr.stage_sel <= 3'h3;
    upd(4);
    chk(cmd.freq, 32'h000005DC);
    wr(`SSQ_ADDR_OFFSET, 32'h000003E8, 2'h0);
    wr(`SSQ_ADDR_CTRL, 32'h00000014, 2'h0);
    tr.stage_sel <= 3'h0;
    n = 0;
    while (cmd.stage !== 3'h1 && n < 900) begin upd(1); n++; end
    tmo(n);
    upd(1);
    chk(cmd.freq, 32'h000001F4);
    n = 1;
    while (cmd.stage !== 3'h2 && n < 900) begin upd(1); n++; end
    chk(n, 32'(200 * TK + 1));
    tr.run <= 1'b0;
    upd(4);
    chk(cmd.run, 32'h0);
    end_sim();
  end
endmodule : ssq_sequencer_tb
